// File: verilog/pciw_pkg.sv
package pciw_pkg;

  // ==========================================================
  // Register offsets (low six bits of a socket-relative address)
  localparam logic [5:0] OFS_CTRL = 6'h07;
  localparam logic [5:0] OFS_W0_LO = 6'h08;
  localparam logic [5:0] OFS_W0_HI = 6'h09;
  localparam logic [5:0] OFS_W1_LO = 6'h0c;
  localparam logic [5:0] OFS_W1_HI = 6'h0d;
  // Upper address bits for indexed and memory-mapped access
  localparam logic [5:0] IDX_HI_B = 6'h01;
  localparam logic [5:0] MM_HI = 6'h20;
  localparam int SOCK_BIT = 6;

  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] ADDR_RST = 8'h00;

  // ==========================================================
  // Field positions inside one window nibble
  localparam int FLD_EXTRA = 3;
  localparam int FLD_SHORT = 2;
  localparam int FLD_AUTO = 1;
  localparam int FLD_WIDTH = 0;

  // ==========================================================
  // Timing: clock period and ISA bus clock period, in ns
  localparam int CLK_PERIOD_NS = 4;
  localparam int ISA_CLK_NS = 120;
  localparam int ISA_DIV = ISA_CLK_NS / CLK_PERIOD_NS;
  // Cycle lengths in ISA clocks
  localparam logic [3:0] LEN_STD8 = 4'h6;
  localparam logic [3:0] LEN_STD16 = 4'h3;
  localparam logic [3:0] LEN_SHORT8 = 4'h3;
  localparam logic [3:0] LEN_EXTRA = 4'h1;

  // ==========================================================
  // Types
  typedef struct packed {
    logic win1_extra_wait;
    logic win1_short_8bit;
    logic win1_auto_size;
    logic win1_width_sel;
    logic win0_extra_wait;
    logic win0_short_8bit;
    logic win0_auto_size;
    logic win0_width_sel;
  } pciw_ctrl_t;

  typedef struct packed {
    pciw_ctrl_t ctrl;
    logic [15:0] w0_start;
    logic [15:0] w1_start;
  } pciw_sock_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_RUN = 2'b01,
    CS_DONE = 2'b11
  } pciw_cstate_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic mm;
    logic mm_sock;
    logic [11:0] addr;
    logic [7:0] wdata;
  } pciw_reg_req_t;

  typedef struct packed {
    logic req;
    logic win;
    logic iois16;
  } pciw_cyc_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic wide;
  } pciw_cyc_stat_t;

  typedef struct packed {
    pciw_cstate_t state;
    logic [3:0] cnt;
  } pciw_cyc_t;

  typedef struct packed {
    pciw_sock_t [1:0] sock;
    pciw_cyc_t [1:0] cyc;
    pciw_cyc_stat_t [1:0] stat;
    logic [7:0] div;
    logic tick;
    logic [7:0] rdata;
  } pciw_state_t;

  localparam pciw_state_t STATE_RST = '0;

endpackage

// File: verilog/pciw_io_window.sv
`timescale 1ns/1ps
// Overview of operation
// - Window 1 extra-wait bit set adds one ISA wait state to 16-bit window 1 cycles.
// - Window 1 extra-wait bit does not change 8-bit window 1 cycles.
// - Window 1 short bit set cuts 8-bit window 1 cycles to three ISA clocks.
// - Window 1 short bit does not change 16-bit window 1 cycles.
// - Window 1 auto-size bit set takes the width from the card's 16-bit indication.
// - Window 1 width bit picks 8 or 16 bits and is ignored while auto-size is set.
// - Window 0 extra-wait bit set adds one ISA wait state to 16-bit window 0 cycles only.
// - Window 0 short bit set cuts 8-bit window 0 cycles to three ISA clocks only.
// - Window 0 auto-size bit set takes the width from the card's 16-bit indication.
// - Window 0 width bit picks 8 or 16 bits and is ignored while auto-size is set.
// - Wait-state lengths are counted in ISA-equivalent bus clocks.
// - Each socket owns a control register at 07h / 47h, also at socket base plus 807h.
// - The control register resets to all zeros.
// - Each window has a read/write start-address low byte at 08h and 0Ch (48h, 4Ch).
// - Each window start address is 16 bits, with a high byte at 09h and 0Dh.
module pciw_io_window (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port
  input wire pciw_pkg::pciw_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Per-socket I/O cycle requests from the host side
  input wire pciw_pkg::pciw_cyc_req_t [1:0] cyc_req,
  // Per-socket cycle status
  output pciw_pkg::pciw_cyc_stat_t [1:0] cyc_stat,
  // Per-socket window settings
  output pciw_pkg::pciw_ctrl_t [1:0] win_ctrl,
  output logic [1:0][15:0] win0_start,
  output logic [1:0][15:0] win1_start
);
  import pciw_pkg::*;

  // ==========================================================
  // Cycle sizing helpers

  // Width of a transfer from one window nibble
  function automatic logic cyc_wide(input logic [3:0] sel, input logic iois16);
    if (sel[FLD_AUTO]) begin
      cyc_wide = iois16;
    end else begin
      cyc_wide = sel[FLD_WIDTH];
    end
  endfunction

  // Cycle length in ISA clocks from nibble and width
  function automatic logic [3:0] cyc_len(input logic [3:0] sel, input logic w16);
    if (w16) begin
      // Short bit plays no part here
      if (sel[FLD_EXTRA]) begin
        cyc_len = LEN_STD16 + LEN_EXTRA;
      end else begin
        cyc_len = LEN_STD16;
      end
    end else begin
      // Extra-wait bit plays no part here
      if (sel[FLD_SHORT]) begin
        cyc_len = LEN_SHORT8;
      end else begin
        cyc_len = LEN_STD8;
      end
    end
  endfunction

  // ==========================================================
  // State

  pciw_state_t s_r;
  pciw_state_t s_nxt;
  logic sk;
  logic [5:0] ofs;
  logic hit;
  logic [3:0] nib;
  logic wide;

  // ==========================================================
  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    sk = 1'b0;
    ofs = reg_req.addr[5:0];
    hit = 1'b0;
    nib = 4'h0;
    wide = 1'b0;

    // ISA clock enable from a divider
    s_nxt.tick = 1'b0;
    if (s_r.div == 8'(ISA_DIV - 1)) begin
      s_nxt.div = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 8'h01;
    end

    // Address decode: indexed or memory-mapped view of a socket
    if (reg_req.mm) begin
      sk = reg_req.mm_sock;
      hit = (reg_req.addr[11:6] == MM_HI);
    end else begin
      sk = reg_req.addr[SOCK_BIT];
      hit = (reg_req.addr[11:7] == 5'h00);
    end
    if (!reg_req.mm && reg_req.addr[SOCK_BIT]) begin
      hit = hit && (reg_req.addr[11:6] == IDX_HI_B);
    end

    // Register writes
    if (reg_req.wr && hit) begin
      if (ofs == OFS_CTRL) begin
        s_nxt.sock[sk].ctrl = reg_req.wdata;
      end else if (ofs == OFS_W0_LO) begin
        s_nxt.sock[sk].w0_start[7:0] = reg_req.wdata;
      end else if (ofs == OFS_W0_HI) begin
        s_nxt.sock[sk].w0_start[15:8] = reg_req.wdata;
      end else if (ofs == OFS_W1_LO) begin
        s_nxt.sock[sk].w1_start[7:0] = reg_req.wdata;
      end else if (ofs == OFS_W1_HI) begin
        s_nxt.sock[sk].w1_start[15:8] = reg_req.wdata;
      end
    end

    // Register reads, unmapped offsets answer zero
    if (reg_req.rd) begin
      s_nxt.rdata = 8'h00;
      if (hit) begin
        if (ofs == OFS_CTRL) begin
          s_nxt.rdata = s_r.sock[sk].ctrl;
        end else if (ofs == OFS_W0_LO) begin
          s_nxt.rdata = s_r.sock[sk].w0_start[7:0];
        end else if (ofs == OFS_W0_HI) begin
          s_nxt.rdata = s_r.sock[sk].w0_start[15:8];
        end else if (ofs == OFS_W1_LO) begin
          s_nxt.rdata = s_r.sock[sk].w1_start[7:0];
        end else if (ofs == OFS_W1_HI) begin
          s_nxt.rdata = s_r.sock[sk].w1_start[15:8];
        end else begin
          s_nxt.rdata = 8'h00;
        end
      end
    end

    // Per-socket I/O cycle timers
    for (int i = 0; i < 2; i++) begin
      if (cyc_req[i].win) begin
        nib = s_r.sock[i].ctrl[7:4];
      end else begin
        nib = s_r.sock[i].ctrl[3:0];
      end
      wide = cyc_wide(nib, cyc_req[i].iois16);
      case (s_r.cyc[i].state)
        CS_IDLE: begin
          s_nxt.stat[i].done = 1'b0;
          if (cyc_req[i].req) begin
            // Width and length latched at the request
            s_nxt.stat[i].wide = wide;
            s_nxt.stat[i].busy = 1'b1;
            s_nxt.cyc[i].cnt = cyc_len(nib, wide);
            s_nxt.cyc[i].state = CS_RUN;
          end
        end
        CS_RUN: begin
          if (s_r.tick) begin
            if (s_r.cyc[i].cnt == 4'h1) begin
              s_nxt.cyc[i].state = CS_DONE;
              s_nxt.stat[i].done = 1'b1;
              s_nxt.stat[i].busy = 1'b0;
            end else begin
              s_nxt.cyc[i].cnt = s_r.cyc[i].cnt - 4'h1;
            end
          end
        end
        CS_DONE: begin
          s_nxt.stat[i].done = 1'b0;
          s_nxt.cyc[i].state = CS_IDLE;
        end
        default: begin
          s_nxt.cyc[i].state = CS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register, synchronous reset to zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  assign reg_rdata = s_r.rdata;
  assign cyc_stat = s_r.stat;
  assign win_ctrl = {s_r.sock[1].ctrl, s_r.sock[0].ctrl};
  assign win0_start = {s_r.sock[1].w0_start, s_r.sock[0].w0_start};
  assign win1_start = {s_r.sock[1].w1_start, s_r.sock[0].w1_start};

endmodule // pciw_io_window

// File: sim/pciw_card_model.sv
`timescale 1ns/1ps
// =====
// Card side: flags 16-bit for its upper I/O range
module pciw_card_model #(
  parameter logic [15:0] WIDE_BASE = 16'h0200
) (
  // Decoded address
  input wire logic [15:0] io_addr,
  // Width flag
  output logic iois16
);
  // Flag follows the decoded address only
  assign iois16 = (io_addr >= WIDE_BASE);
endmodule // pciw_card_model

// File: sim/pciw_io_window_asserts.sv
`timescale 1ns/1ps
// =====
// Port checker
module pciw_io_window_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Watched ports
  input wire pciw_pkg::pciw_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire pciw_pkg::pciw_cyc_req_t [1:0] cyc_req,
  input wire pciw_pkg::pciw_cyc_stat_t [1:0] cyc_stat,
  input wire pciw_pkg::pciw_ctrl_t [1:0] win_ctrl,
  input wire logic [1:0][15:0] win0_start,
  input wire logic [1:0][15:0] win1_start
);
  import pciw_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic wa;
  logic go;
  logic [11:0] ad;
  logic pick;
  // Indexed write and idle start decode
  assign wa = reg_req.wr && !reg_req.mm;
  assign ad = reg_req.addr;
  assign go = cyc_req[0].req && !cyc_stat[0].busy && !cyc_stat[0].done;
  // Expected width of a socket A request from its window bits
  assign pick = cyc_req[0].win ?
    (win_ctrl[0].win1_auto_size ? cyc_req[0].iois16 : win_ctrl[0].win1_width_sel) :
    (win_ctrl[0].win0_auto_size ? cyc_req[0].iois16 : win_ctrl[0].win0_width_sel);
  a_ctrl_reset: assert property (disable iff (1'b0) sys_rst |=> win_ctrl == '0)
    else $error("ctrl not cleared");
  a_sock_a: assert property (wa && ad == 12'h007 |=> win_ctrl[0] == $past(reg_req.wdata))
    else $error("ctrl A write");
  a_sock_b: assert property (wa && ad == 12'h047 |=> win_ctrl[1] == $past(reg_req.wdata))
    else $error("ctrl B write");
  a_mm_ctrl: assert property (reg_req.wr && reg_req.mm && !reg_req.mm_sock && ad == 12'h807
    |=> win_ctrl[0] == $past(reg_req.wdata))
    else $error("mm ctrl write");
  a_ctrl_read: assert property (reg_req.rd && !reg_req.wr && !reg_req.mm && ad == 12'h007
    |=> reg_rdata == $past(win_ctrl[0]))
    else $error("ctrl read");
  a_low_w0: assert property (wa && ad == 12'h008 |=> win0_start[0][7:0] == $past(reg_req.wdata))
    else $error("w0 low write");
  a_low_w1: assert property (wa && ad == 12'h04c |=> win1_start[1][7:0] == $past(reg_req.wdata))
    else $error("w1 low write");
  a_cycle_start: assert property (go |=> cyc_stat[0].busy)
    else $error("busy missing");
  a_done_once: assert property (cyc_stat[0].done |=> !cyc_stat[0].done && !cyc_stat[0].busy)
    else $error("done too long");
  a_width_pick: assert property (go |=> cyc_stat[0].wide == $past(pick))
    else $error("width choice");
endmodule // pciw_io_window_asserts

bind pciw_io_window pciw_io_window_asserts u_pciw_io_window_asserts (.clock(clock),
  .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .cyc_req(cyc_req),
  .cyc_stat(cyc_stat), .win_ctrl(win_ctrl), .win0_start(win0_start), .win1_start(win1_start));

// File: sim/pciw_io_window_tb.sv
`timescale 1ns/1ps
// =====
// Bench top
module pciw_io_window_tb;
  import pciw_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  pciw_reg_req_t rq = '0;
  logic [7:0] rdat;
  pciw_cyc_req_t [1:0] cq;
  pciw_cyc_stat_t [1:0] cs;
  pciw_ctrl_t [1:0] wc;
  logic [1:0][15:0] w0s;
  logic [1:0][15:0] w1s;
  logic cr = 1'b0;
  logic cw = 1'b0;
  logic cr1 = 1'b0;
  logic [15:0] ioa = 16'h0000;
  logic io16;
  int err_total = 0;
  int check_count = 0;
  int cyc_n = 0;
  // Cycle table: control, window, card range, ISA ticks, width
  logic [7:0] t_ctrl [10] = '{8'h00, 8'h0c, 8'h0d, 8'h02, 8'h03, 8'h80, 8'hc0, 8'hd0, 8'he0, 8'h30};
  logic [9:0] t_win = 10'h3e0;
  logic [9:0] t_card = 10'h108;
  logic [9:0] t_wide = 10'h18c;
  int t_n [10] = '{6, 3, 4, 3, 6, 6, 3, 4, 4, 6};
  // Both sockets share window select and card flag, each has its own request
  assign cq[0] = '{req: cr, win: cw, iois16: io16};
  assign cq[1] = '{req: cr1, win: cw, iois16: io16};
  // Clock
  initial begin
    forever #2 clock = ~clock;
  end
  pciw_io_window u_pciw_io_window (.clock(clock), .sys_rst(sys_rst), .reg_req(rq),
    .reg_rdata(rdat), .cyc_req(cq), .cyc_stat(cs), .win_ctrl(wc), .win0_start(w0s),
    .win1_start(w1s));
  pciw_card_model u_pciw_card_model (.io_addr(ioa), .iois16(io16));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input logic m, input logic s, input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    rq <= '{rd: 1'b0, wr: 1'b1, mm: m, mm_sock: s, addr: a, wdata: d};
    @(posedge clock);
    rq.wr <= 1'b0;
  endtask
  task rd(input logic m, input logic s, input logic [11:0] a, input logic [7:0] e);
    @(posedge clock);
    rq <= '{rd: 1'b1, wr: 1'b0, mm: m, mm_sock: s, addr: a, wdata: 8'h00};
    @(posedge clock);
    rq.rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask
  // One I/O cycle from table row i on socket s, timed from the taking edge
  task run(input int i, input logic s);
    int c;
    c = 0;
    wr(t_win[i], s, t_win[i] ? 12'h807 : (s ? 12'h047 : 12'h007), t_ctrl[i]);
    @(posedge clock);
    cr <= !s;
    cr1 <= s;
    cw <= t_win[i];
    ioa <= t_card[i] ? 16'h0300 : 16'h0010;
    @(posedge clock);
    cr <= 1'b0;
    cr1 <= 1'b0;
    #1;
    chk(cs[s].busy, 1'b1);
    chk(cs[!s].busy, 1'b0);
    while (c < 400 && cs[s].done !== 1'b1) begin
      @(posedge clock);
      #1;
      c++;
    end
    chk(cs[s].wide, t_wide[i]);
    chk(c >= (t_n[i] - 1) * 30 + 1 && c <= t_n[i] * 30 + 1, 1'b1);
  endtask
  task give_verdict;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd(1'b0, 1'b0, 12'h007, 8'h00);
    wr(1'b0, 1'b0, 12'h047, 8'ha5);
    rd(1'b1, 1'b1, 12'h807, 8'ha5);
    wr(1'b0, 1'b0, 12'h008, 8'h5a);
    wr(1'b0, 1'b0, 12'h009, 8'h12);
    wr(1'b0, 1'b0, 12'h04c, 8'hc3);
    rd(1'b1, 1'b0, 12'h808, 8'h5a);
    rd(1'b0, 1'b0, 12'h04c, 8'hc3);
    chk(w0s[0], 16'h125a);
    chk(w1s[1], 16'h00c3);
    rd(1'b0, 1'b0, 12'h100, 8'h00);
    for (int i = 0; i < 10; i++) begin
      run(i, 1'b0);
    end
    run(2, 1'b1);
    run(8, 1'b1);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    #1;
    chk(wc, 16'h0000);
    give_verdict;
  end
endmodule // pciw_io_window_tb
